// ### bench/tb_pci_initiator_user_port.sv
// self-checking bench: user machine model plus arbiter and target stand-ins
// assumes the port answers apb with no wait states and samples target lines at edges
`timescale 1ns/1ns
`include "pci_init_defines.svh"
module tb_pci_initiator_user_port
   import pci_init_pkg::*;
;
   localparam logic [31:0] RD_PAT = 32'h1234_abcd;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        grant = 1'b0;
   logic        start = 1'b0;
   logic        dir = 1'b0;
   logic [1:0]  tmode = 2'h0;
   logic [7:0]  fcnt = 8'h00;
   logic [31:0] addr = 32'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] aseen, wseen, prdata, rd, uadio, urd, ad_o, ad_i, mrd;
   logic [3:0]  cseen, ucbe, cbe_o;
   logic [7:0]  ext, tries;
   logic        pready, pslverr, err, ready, ask, hold, fin, udir, strobe_n, gate, dpa, beat;
   logic        arb, frame, irdy, ad_oe, idle, dead, claim, trdy, stop, act;
   int          errors = 0;
   int          checks = 0;
   assign act = frame | irdy;
   assign claim = act & (tmode == 2'h0 | tmode == 2'h1 | (tmode == 2'h2 & fcnt == 8'h00));
   assign trdy = act & (tmode == 2'h0 | (tmode == 2'h1 & tries != 8'h01));
   assign stop = act & ((tmode == 2'h1 & tries == 8'h01) | (tmode == 2'h2 & fcnt != 8'h00));
   assign ad_i = ad_oe ? ad_o : (claim ? RD_PAT : ~ad_o);
   always_ff @(posedge clk) begin
      grant <= arb;
      fcnt <= act ? fcnt + 8'h01 : 8'h00;
      if (frame & fcnt == 8'h00) begin
         aseen <= ad_o;
         cseen <= cbe_o;
      end
      if (beat & udir) begin
         wseen <= ad_o;
      end
   end
   pci_initiator_port #(.MABORT_CLKS(2)) dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_initiator_ready_in(ready), .i_bus_ask_pulse(ask),
      .i_bus_ask_hold(hold), .i_finish_txn(fin), .i_xfer_direction_write(udir), .i_user_shared_addr_data_bus(uadio),
      .i_cmd_byte_lane_bus(ucbe), .o_user_shared_addr_data_bus(urd), .o_addr_phase_strobe_n(strobe_n),
      .o_addr_drive_gate(gate), .o_data_phase_active(dpa), .o_data_beat_valid(beat),
      .o_ext_status_bus(ext), .o_arb_ask_line(arb), .i_arb_grant(grant), .o_pci_frame(frame),
      .o_pci_irdy(irdy), .o_pci_ad(ad_o), .o_pci_ad_oe(ad_oe), .i_pci_ad(ad_i), .o_pci_cbe(cbe_o),
      .i_tgt_claim(claim), .i_tgt_ready(trdy), .i_tgt_stop(stop));
   user_app_model ua (.i_core_clk(clk), .i_reset_n(rst_n), .i_start(start), .i_dir(dir), .i_addr(addr),
      .i_wdata(wdat), .i_strobe_n(strobe_n), .i_gate(gate), .i_dpa(dpa), .i_beat(beat), .i_ext(ext),
      .i_rd(urd), .o_ready(ready), .o_ask(ask), .o_hold(hold), .o_finish(fin), .o_dir(udir),
      .o_shared_addr_data_bus(uadio), .o_cbe(ucbe), .o_idle(idle), .o_dead(dead), .o_tries(tries), .o_rdata(mrd));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         if (n == 50) begin
            errors++;
            stop_test();
         end
         @(posedge clk);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic go(input logic wr, input logic [1:0] mode, input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, `REG_STAT_OFF, 32'h0000_000f);
      tmode <= mode;
      dir <= wr;
      addr <= a;
      wdat <= d;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_end();
      int n;
      n = 0;
      while (!(idle | dead)) begin
         if (n == 400) begin
            errors++;
            stop_test();
         end
         @(posedge clk);
         n++;
      end
      apb(1'b0, `REG_STAT_OFF, 32'h0);
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b1, `REG_CTRL_OFF, 32'h1);
   endtask
   task automatic t_regs();
      apb(1'b0, `REG_CTRL_OFF, 32'h0);
      check(rd, `CTRL_RESET);
      apb(1'b0, 12'h008, 32'h0);
      check({31'h0, err}, 32'h1);
   endtask
   task automatic t_enable();
      int n;
      n = 0;
      go(1'b0, 2'h0, 32'h0000_1a40, 32'h0);
      repeat (20) begin
         @(posedge clk);
         check({31'h0, arb}, 32'h0);
      end
      apb(1'b0, `REG_STAT_OFF, 32'h0);
      check(rd, 32'h0000_0100);
      apb(1'b1, `REG_CTRL_OFF, 32'h1);
      while (arb !== 1'b1 && n < 10) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, arb}, 32'h1);
      wait_end();
      check(aseen, 32'h0000_1a40);
      check({28'h0, cseen}, 32'h6);
      check(urd, RD_PAT);
      check(mrd, RD_PAT);
      check({24'h0, ext}, 32'h0);
      check(rd, 32'h1);
   endtask
   task automatic t_write();
      go(1'b1, 2'h0, 32'h0000_2000, 32'h5a5a_c3c3);
      wait_end();
      check({28'h0, cseen}, 32'h7);
      check(wseen, 32'h5a5a_c3c3);
      check(rd, 32'h1);
   endtask
   task automatic t_retry();
      go(1'b1, 2'h1, 32'h0000_3004, 32'h0f1e_2d3c);
      wait_end();
      check({24'h0, tries}, 32'h2);
      check(rd, 32'h3);
      check(wseen, 32'h0f1e_2d3c);
   endtask
   task automatic t_tabort();
      go(1'b0, 2'h2, 32'h0000_4008, 32'h0);
      wait_end();
      check({31'h0, dead}, 32'h1);
      check({24'h0, ext & 8'hc0}, 32'h40);
      check(rd, 32'h4);
      do_reset();
   endtask
   task automatic t_mabort();
      go(1'b0, 2'h3, 32'h0000_500c, 32'h0);
      wait_end();
      check({31'h0, dead}, 32'h1);
      check({24'h0, ext & 8'hc0}, 32'h80);
      check(rd, 32'h8);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_enable();
      t_write();
      t_retry();
      t_tabort();
      t_mabort();
      stop_test();
   end
endmodule

// ### bench/user_app_model.sv
// user application control machine model driving the initiator user port
// assumes the port's strobe, gate, data phase and status outputs share i_core_clk
`timescale 1ns/1ns
module user_app_model
   import pci_init_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_start,
   input  wire logic        i_dir,
   input  wire logic [31:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_strobe_n,
   input  wire logic        i_gate,
   input  wire logic        i_dpa,
   input  wire logic        i_beat,
   input  wire logic [7:0]  i_ext,
   input  wire logic [31:0] i_rd,
   output logic             o_ready,
   output logic             o_ask,
   output logic             o_hold,
   output logic             o_finish,
   output logic             o_dir,
   output logic [31:0]      o_shared_addr_data_bus,
   output logic [3:0]       o_cbe,
   output logic             o_idle,
   output logic             o_dead,
   output logic [7:0]       o_tries,
   output logic [31:0]      o_rdata
);
   typedef enum logic [2:0] {P_IDLE, P_REQ, P_RD, P_WR, P_RETRY, P_DONE, P_DEAD} part_state_t;
   part_state_t st_r;
   logic        dpa_q_r;
   logic        fatal_r;
   logic        retry_r;
   logic        load_q_r;
   logic [31:0] last_r;
   wire         fell = !i_dpa & dpa_q_r;
   assign o_ask = (st_r == P_REQ);
   assign o_hold = 1'b0;
   assign o_cbe = i_strobe_n ? 4'h0 : {3'b011, o_dir};
   // released lanes show the inverse of the last value, never a stale copy
   assign o_shared_addr_data_bus = !i_gate ? i_addr : (st_r == P_WR && i_dpa) ? i_wdata : ~last_r;
   assign o_idle = (st_r == P_IDLE);
   assign o_dead = (st_r == P_DEAD);
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_r <= P_IDLE;
         o_ready <= 1'b0;
         o_finish <= 1'b0;
         o_dir <= 1'b0;
         dpa_q_r <= 1'b0;
         fatal_r <= 1'b0;
         retry_r <= 1'b0;
         load_q_r <= 1'b0;
         o_tries <= 8'h00;
         last_r <= 32'h0000_0000;
         o_rdata <= 32'h0000_0000;
      end else begin
         o_ready <= 1'b1;
         o_finish <= (st_r == P_REQ || st_r == P_RD || st_r == P_WR);
         dpa_q_r <= i_dpa;
         // remember only what was really driven, so the released value stays put
         if (!i_gate || (st_r == P_WR && i_dpa)) begin
            last_r <= o_shared_addr_data_bus;
         end
         load_q_r <= (st_r == P_RD) & i_beat;
         if (load_q_r) begin
            o_rdata <= i_rd;
         end
         if (!i_strobe_n) begin
            fatal_r <= 1'b0;
            retry_r <= 1'b0;
         end else if (i_dpa) begin
            fatal_r <= i_ext[7] | i_ext[6];
            retry_r <= i_ext[4];
         end
         if (st_r == P_IDLE && i_start) begin
            o_dir <= i_dir;
            o_tries <= 8'h00;
         end
         if (st_r == P_REQ) begin
            o_tries <= o_tries + 8'h01;
         end
         case (st_r)
            P_IDLE: if (i_start) st_r <= P_REQ;
            P_REQ: st_r <= o_dir ? P_WR : P_RD;
            P_RD, P_WR: if (fell) st_r <= fatal_r ? P_DEAD : retry_r ? P_RETRY : P_DONE;
            P_RETRY: st_r <= P_REQ;
            P_DONE: st_r <= P_IDLE;
            default: st_r <= st_r;
         endcase
      end
   end
endmodule

// ### core/init_apb_regs.sv
// apb slave holding the control and sticky termination status words
// assumes a single apb master on i_core_clk; answers with zero wait states
`timescale 1ns/1ns
`include "pci_init_defines.svh"

module init_apb_regs
   import pci_init_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire term_t       i_term,
   input  wire logic        i_term_vld,
   input  wire logic        i_busy,
   output logic             o_bus_master_en
);

   logic [31:0] ctrl_r;
   logic [31:0] ctrl_nxt;
   term_t       stat_r;
   term_t       stat_nxt;
   logic        acc;
   logic        hit_ctrl;
   logic        hit_stat;

   assign acc       = i_psel & i_penable;
   assign hit_ctrl  = (i_paddr == `REG_CTRL_OFF);
   assign hit_stat  = (i_paddr == `REG_STAT_OFF);
   assign o_pready  = 1'b1;
   assign o_pslverr = acc & ~hit_ctrl & ~hit_stat;
   assign o_bus_master_en = ctrl_r[`CTRL_BME_BIT];

   always_comb begin
      ctrl_nxt = ctrl_r;
      stat_nxt = stat_r;
      if (acc & i_pwrite & hit_ctrl) begin
         ctrl_nxt = {31'h0, i_pwdata[`CTRL_BME_BIT]};
      end
      // write one to clear; a new outcome in the same cycle wins
      if (acc & i_pwrite & hit_stat) begin
         stat_nxt = stat_r & ~term_t'(i_pwdata[3:0]);
      end
      if (i_term_vld) begin
         stat_nxt = stat_nxt | i_term;
      end
   end

   always_comb begin
      o_prdata = 32'h0000_0000;
      if (acc & ~i_pwrite & hit_ctrl) begin
         o_prdata = ctrl_r;
      end else if (acc & ~i_pwrite & hit_stat) begin
         o_prdata = {23'h0, i_busy, 4'h0, stat_r};
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl_r <= `CTRL_RESET;
         stat_r <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         stat_r <= stat_nxt;
      end
   end

endmodule

// ### core/pci_init_defines.svh
// offsets, field positions, reset values and counts of the initiator user port
// assumes inclusion by bare name from the design and bench files
`ifndef PCI_INIT_DEFINES_SVH
`define PCI_INIT_DEFINES_SVH

`define REG_CTRL_OFF      12'h000
`define REG_STAT_OFF      12'h004
`define CTRL_BME_BIT      0
`define CTRL_RESET        32'h0000_0000
`define STAT_DONE_BIT     0
`define STAT_RETRY_BIT    1
`define STAT_TABORT_BIT   2
`define STAT_MABORT_BIT   3
`define STAT_BUSY_BIT     8
`define EXT_MABORT_BIT    7
`define EXT_TABORT_BIT    6
`define EXT_DISC_BIT      4
`define MABORT_CLKS       5

`endif

// ### core/pci_init_pkg.sv
// types shared by the initiator user port and its register slave
// assumes the defines header supplies all numeric constants
package pci_init_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ASK,
      ST_ADDR,
      ST_DATA,
      ST_LAST
   } init_state_t;

   typedef struct packed {
      logic master_abort;
      logic target_abort;
      logic retry;
      logic done;
   } term_t;

endpackage

// ### core/pci_initiator_port.sv
// initiator user port of a pci interface: single or burst memory transfers
// assumes active-high abstracted pci control pins and a user machine that
// follows the documented request, direction and finish sequencing
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
`include "pci_init_defines.svh"

// Summary of operation
// (R1) user raises ready before asking
// (R2) user never ties ready constant; the bench user model holds ready high in every cycle after reset
// (R3) user pulses ask one cycle
// (R4) ask pulse raises arbiter request line
// (R5) no request without bus master enable
// (R6) unused ask hold driven zero
// (R7) address captured at strobe, presented on bus
// (R8) user releases address outside address phase
// (R9) user drives read/write memory command
// (R10) user drives active-low byte enables otherwise
// (R11) direction held for whole transaction
// (R12) direction never tied constant
// (R13) finish within one cycle of ask
// (R14) finish never tied constant
// (R15) user loads read data on beat valid; the bench user model loads it one cycle after beat valid
// (R16) user drives write data during data phase
// (R17) user drives all write byte lanes
// (R18) read load may be gated per byte
// (R19) retry moves no data; reissue request
// (R20) unclaimed transaction ends as master abort
// (R21) user handles aborts explicitly
// (R22) extended status one cycle after event
// (R23) data phase flag follows transfer state
// (R24) direction high write, low read
module pci_initiator_port
   import pci_init_pkg::*;
#(
   parameter int MABORT_CLKS = `MABORT_CLKS
)
(
   input  wire logic        i_core_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_initiator_ready_in,
   input  wire logic        i_bus_ask_pulse,
   input  wire logic        i_bus_ask_hold,
   input  wire logic        i_finish_txn,
   input  wire logic        i_xfer_direction_write,
   input  wire logic [31:0] i_user_shared_addr_data_bus,
   input  wire logic [3:0]  i_cmd_byte_lane_bus,
   output logic [31:0]      o_user_shared_addr_data_bus,
   output logic             o_addr_phase_strobe_n,
   output logic             o_addr_drive_gate,
   output logic             o_data_phase_active,
   output logic             o_data_beat_valid,
   output logic [7:0]       o_ext_status_bus,
   output logic             o_arb_ask_line,
   input  wire logic        i_arb_grant,
   output logic             o_pci_frame,
   output logic             o_pci_irdy,
   output logic [31:0]      o_pci_ad,
   output logic             o_pci_ad_oe,
   input  wire logic [31:0] i_pci_ad,
   output logic [3:0]       o_pci_cbe,
   input  wire logic        i_tgt_claim,
   input  wire logic        i_tgt_ready,
   input  wire logic        i_tgt_stop
);

   generate
      if (MABORT_CLKS < 1 || MABORT_CLKS > 15) begin : g_bad_count
         $error("MABORT_CLKS must lie in 1..15");
      end
   endgenerate

   localparam logic [3:0] MA_LIMIT = 4'(MABORT_CLKS);

   init_state_t state_r;
   init_state_t state_nxt;
   logic        pend_r;
   logic        pend_nxt;
   logic [3:0]  cnt_r;
   logic [3:0]  cnt_nxt;
   logic        claimed_r;
   logic        claimed_nxt;
   logic [7:0]  ext_r;
   logic [7:0]  ext_nxt;
   logic [31:0] ad_r;
   logic [31:0] ad_nxt;
   logic [3:0]  cbe_r;
   logic [3:0]  cbe_nxt;
   logic        oe_r;
   logic        oe_nxt;
   logic [31:0] rd_r;
   logic [31:0] rd_nxt;
   term_t       term;
   logic        term_vld;
   logic        bme;
   logic        in_data;
   logic        beat;
   logic        ev_retry;
   logic        ev_tabort;
   logic        ev_mabort;
   logic        ev_done;

   init_apb_regs u_regs (
      .i_core_clk      (i_core_clk),
      .i_reset_n       (i_reset_n),
      .i_psel          (i_psel),
      .i_penable       (i_penable),
      .i_pwrite        (i_pwrite),
      .i_paddr         (i_paddr),
      .i_pwdata        (i_pwdata),
      .o_prdata        (o_prdata),
      .o_pready        (o_pready),
      .o_pslverr       (o_pslverr),
      .i_term          (term),
      .i_term_vld      (term_vld),
      .i_busy          (state_r != ST_IDLE),
      .o_bus_master_en (bme)
   );

   assign in_data = (state_r == ST_DATA);
   assign o_arb_ask_line = bme & ((state_r == ST_ASK) | i_bus_ask_hold);  // R4 R5
   assign o_addr_phase_strobe_n = ~(state_r == ST_ADDR);                // R7
   assign o_addr_drive_gate     = o_addr_phase_strobe_n;
   assign o_data_phase_active   = in_data | (state_r == ST_LAST);        // R23
   assign o_pci_frame = in_data & ((cnt_r == 4'h0) | ~i_finish_txn);
   assign o_pci_irdy  = in_data & (cnt_r != 4'h0) & i_initiator_ready_in;
   assign beat        = o_pci_irdy & i_tgt_claim & i_tgt_ready;
   assign o_data_beat_valid = beat;
   // outcome decode, the four terms are mutually exclusive, no priority between them
   assign ev_done   = beat & (i_finish_txn | i_tgt_stop);
   assign ev_retry  = in_data & ~beat & i_tgt_claim & i_tgt_stop;        // R19
   assign ev_tabort = in_data & claimed_r & ~i_tgt_claim & i_tgt_stop;
   assign ev_mabort = in_data & ~claimed_r & ~i_tgt_claim & (cnt_r == MA_LIMIT);  // R20
   assign term      = '{master_abort: ev_mabort, target_abort: ev_tabort,
                        retry: ev_retry, done: ev_done};
   assign term_vld  = ev_done | ev_retry | ev_tabort | ev_mabort;
   assign o_pci_ad    = ad_r;
   assign o_pci_ad_oe = oe_r;
   assign o_pci_cbe   = cbe_r;
   assign o_user_shared_addr_data_bus = rd_r;
   assign o_ext_status_bus = ext_r;

   always_comb begin
      state_nxt   = state_r;
      pend_nxt    = pend_r | i_bus_ask_pulse;
      cnt_nxt     = cnt_r;
      claimed_nxt = claimed_r;
      ext_nxt     = ext_r;
      ad_nxt      = ad_r;
      cbe_nxt     = cbe_r;
      oe_nxt      = 1'b0;
      rd_nxt      = rd_r;
      unique case (state_r)
         ST_IDLE: begin
            if (pend_r) begin
               state_nxt = ST_ASK;
            end
         end
         ST_ASK: begin
            if (bme & i_arb_grant) begin                                // R5
               state_nxt = ST_ADDR;
               pend_nxt  = i_bus_ask_pulse;
            end
         end
         ST_ADDR: begin
            ad_nxt      = i_user_shared_addr_data_bus;                                  // R7
            cbe_nxt     = i_cmd_byte_lane_bus;
            oe_nxt      = 1'b1;
            ext_nxt     = 8'h00;
            cnt_nxt     = 4'h0;
            claimed_nxt = 1'b0;
            state_nxt   = ST_DATA;
         end
         ST_DATA: begin
            if (cnt_r != 4'hf) begin
               cnt_nxt = cnt_r + 4'h1;
            end
            claimed_nxt = claimed_r | i_tgt_claim;
            ad_nxt      = i_user_shared_addr_data_bus;
            cbe_nxt     = i_cmd_byte_lane_bus;
            oe_nxt      = i_xfer_direction_write;
            if (beat & ~i_xfer_direction_write) begin
               rd_nxt = i_pci_ad;
            end
            ext_nxt[`EXT_MABORT_BIT] = ev_mabort;                       // R22
            ext_nxt[`EXT_TABORT_BIT] = ev_tabort;
            ext_nxt[`EXT_DISC_BIT]   = ev_retry;
            if (term_vld) begin
               state_nxt = ST_LAST;
               oe_nxt    = 1'b0;
            end
         end
         ST_LAST: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r   <= ST_IDLE;
         pend_r    <= 1'b0;
         cnt_r     <= 4'h0;
         claimed_r <= 1'b0;
         ext_r     <= 8'h00;
         ad_r      <= 32'h0000_0000;
         cbe_r     <= 4'h0;
         oe_r      <= 1'b0;
         rd_r      <= 32'h0000_0000;
      end else begin
         state_r   <= state_nxt;
         pend_r    <= pend_nxt;
         cnt_r     <= cnt_nxt;
         claimed_r <= claimed_nxt;
         ext_r     <= ext_nxt;
         ad_r      <= ad_nxt;
         cbe_r     <= cbe_nxt;
         oe_r      <= oe_nxt;
         rd_r      <= rd_nxt;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   AST_ASK_NEEDS_BME: assert property (                         // R5
      (state_r == ST_ASK && !bme) |-> !o_arb_ask_line ##1 state_r == ST_ASK)
      else $error("request line raised without bus master enable");
   AST_ASK_FOLLOWS_PULSE: assert property (                     // R4
      (i_bus_ask_pulse && bme && state_r == ST_IDLE && !i_arb_grant) |=> ##1 o_arb_ask_line)
      else $error("ask pulse did not raise the request line");
   AST_STROBE_ONE_CYCLE: assert property (                      // R7
      !o_addr_phase_strobe_n |=> o_addr_phase_strobe_n && o_pci_frame && o_pci_ad_oe)
      else $error("address strobe not followed by address phase");
   AST_ADDR_PRESENTED: assert property (                        // R7
      !o_addr_phase_strobe_n |=> o_pci_ad == $past(i_user_shared_addr_data_bus) && o_pci_cbe == $past(i_cmd_byte_lane_bus))
      else $error("captured address not presented");
   AST_DPA_TRACKS_STATE: assert property (                      // R23
      (state_r == ST_DATA && term_vld) |=> o_data_phase_active ##1 !o_data_phase_active)
      else $error("data phase flag did not end one cycle after outcome");
   AST_RETRY_STATUS: assert property (                          // R22
      ev_retry |=> o_ext_status_bus[`EXT_DISC_BIT] && !o_ext_status_bus[`EXT_MABORT_BIT])
      else $error("disconnect status not shown one cycle after retry");
   AST_MABORT_STATUS: assert property (                         // R20
      ev_mabort |=> o_ext_status_bus[`EXT_MABORT_BIT] ##1 !o_data_phase_active)
      else $error("master abort not reported");
   AST_RETRY_NO_DATA: assert property (                         // R19
      ev_retry |-> !o_data_beat_valid ##1 $stable(rd_r))
      else $error("data moved on a retried transaction");

   COV_DONE:   cover property (ev_done && !i_xfer_direction_write);
   COV_RETRY:  cover property (ev_retry ##[1:40] ev_done);
   COV_MABORT: cover property (ev_mabort);
   COV_TABORT: cover property (ev_tabort);

endmodule
